// ==== design/scs_clock_ctrl.v ====
// Clock source select, start-up timing, domain gating and PLL control.
// Assumes fuses static, wdosc tick synchronous one-cycle pulse.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "scs_defs.vh"

// Overview of operation
// - PLL output is eight times the RC oscillator, nominal 64 MHz.
// - PLL runs only if enable bit set or PLL fuse reads zero.
// - Lock flag sets once the PLL has locked to its reference.
// - Trim shifts PLL output; above nominal it saturates and unlocks.
// - Power-down and stand-by switch off RC oscillator and PLL.
// - Fast clock, direct or prescaled, selectable for second timer.
// - Four-bit fuse code chooses system clock source; some reserved.
// - Fuse bit zero means programmed, one means unprogrammed.
// - Wake from power-down/save counts start-up cycles before running.
// - Reset start adds a delay timed by the watchdog oscillator.
// - Reset delay counts none, 512 or 8192 watchdog cycles, by start-up fuses.
// - Each sleep mode stops clocks of unused modules only.
// - Core clock gating stops register file, status and stack.
// - Asynchronous external interrupts still detected with I/O clock off.
// - Program memory clock follows core clock enable.
// - Converter clock has its own domain, running during conversion.
// - First clock after reset loads factory calibration byte into trim register; reset itself clears it.
module scs_clock_ctrl #(
  parameter [13:0] TO_SHORT_CYC = `SCS_TO_SHORT_CYC,
  parameter [13:0] TO_LONG_CYC = `SCS_TO_LONG_CYC,
  parameter [15:0] WAKE_CYC = `SCS_WAKE_CYC,
  parameter [15:0] LOCK_CYC = `SCS_PLL_LOCK_CYC,
  parameter [7:0] TRIM_NOMINAL = 8'h80 // Trim code giving 8 MHz
) (
  input wire clk_sys_i, // System clock
  input wire nrst_i, // Async reset, active low
  input wire [3:0] clock_source_select_fuses_i, // Source fuse code
  input wire pll_system_clock_fuse_i, // PLL fuse, 0 = programmed
  input wire [1:0] startup_fuses_i, // 00 none, 01 short, else long
  input wire [7:0] factory_cal_i, // Calibration byte
  input wire wdosc_tick_i, // Watchdog oscillator edge pulse
  input wire src_tick_i, // Selected source edge pulse
  input wire [2:0] sleep_mode_i, // Current sleep mode
  input wire conv_busy_i, // Converter converting
  input wire [`SCS_ADDR_W-1:0] addr_i, // Register address
  input wire [7:0] wdata_i, // Write data
  input wire wr_i, // Write strobe
  input wire rd_i, // Read strobe
  output reg [7:0] rdata_o, // Read data, one cycle later
  output reg [2:0] sys_src_o, // 0 ext,1 pll,2 rc,3 wd,4 lfxt,5 xtal,7 rsv
  output reg [3:0] xtal_mode_o, // Crystal code bits
  output reg [7:0] rc_trim_value_o, // RC trim value
  output reg rc_osc_en_o, // RC oscillator enable
  output reg pll_en_o, // PLL enable
  output reg [6:0] pll_freq_mhz_o, // Modelled fast clock rate
  output reg pll_lock_flag_o, // PLL locked
  output reg [1:0] t2_clk_sel_o, // 0 sys,1 fast direct,2 fast prescaled
  output reg core_clock_en_o, // Core clock enable
  output reg program_memory_clock_en_o, // Program memory clock enable
  output reg peripheral_io_clock_en_o, // I/O clock enable
  output reg converter_clock_en_o, // Converter clock enable
  output reg async_irq_en_o, // Async interrupt detect live
  output reg cpu_run_o // Instruction execution allowed
);

  localparam ST_RSTDLY = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_SLEEP = 2'd2;
  localparam ST_WAKE = 2'd3;

  reg [1:0] state_ff, nxt_state;
  reg [13:0] to_cnt_ff, nxt_to_cnt;
  reg [15:0] wk_cnt_ff, nxt_wk_cnt;
  reg [15:0] lk_cnt_ff;
  reg pll_enable_bit_ff;
  reg [1:0] t2_sel_ff;
  reg cal_ld_ff;
  reg [13:0] to_target;
  reg [2:0] slp_mode_ff;
  wire wake_count;
  wire [12:0] pll_mhz;
  wire pll_fuse_prog;
  wire deep_sleep;
  wire pll_run;
  wire trim_over;
  wire [9:0] rc_tenth_mhz;
  wire [12:0] pll_raw;

  assign pll_fuse_prog = ~pll_system_clock_fuse_i;
  assign deep_sleep = (state_ff == ST_SLEEP) &&
    (sleep_mode_i == `SCS_SLP_PDOWN || sleep_mode_i == `SCS_SLP_STBY);
  assign pll_run = (pll_enable_bit_ff | pll_fuse_prog) & ~deep_sleep;
  assign trim_over = rc_trim_value_o > TRIM_NOMINAL;
  // RC rate in 0.1 MHz steps: 80 at nominal, shifted by trim
  assign rc_tenth_mhz = 10'd80 + {2'b00, rc_trim_value_o[7:1]} -
    {3'b000, TRIM_NOMINAL[7:1]};
  assign pll_raw = {3'b000, rc_tenth_mhz} * 13'd`SCS_PLL_MULT;
  // Tenths of MHz to whole MHz
  assign pll_mhz = pll_raw / 13'd10;
  // Modes that need a counted restart: power-down, power-save, stand-by
  assign wake_count = (slp_mode_ff == `SCS_SLP_PDOWN) ||
    (slp_mode_ff == `SCS_SLP_PSAVE) || (slp_mode_ff == `SCS_SLP_STBY);

  always @* begin
    case (startup_fuses_i)
      2'b00: to_target = 14'd0;
      2'b01: to_target = TO_SHORT_CYC;
      default: to_target = TO_LONG_CYC;
    endcase
  end

  always @* begin
    nxt_state = state_ff;
    nxt_to_cnt = to_cnt_ff;
    nxt_wk_cnt = wk_cnt_ff;
    case (state_ff)
      ST_RSTDLY: begin
        if (wdosc_tick_i) begin
          nxt_to_cnt = to_cnt_ff + 14'd1;
        end
        if (to_cnt_ff >= to_target) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_mode_i != `SCS_SLP_ACTIVE) begin
          nxt_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        nxt_wk_cnt = 16'd0;
        if (sleep_mode_i == `SCS_SLP_ACTIVE) begin
          if (wake_count) begin
            nxt_state = ST_WAKE;
          end else begin
            nxt_state = ST_RUN;
          end
        end
      end
      ST_WAKE: begin
        if (src_tick_i) begin
          nxt_wk_cnt = wk_cnt_ff + 16'd1;
        end
        if (wk_cnt_ff >= WAKE_CYC) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_RSTDLY;
    endcase
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= ST_RSTDLY;
      to_cnt_ff <= 14'd0;
      wk_cnt_ff <= 16'd0;
      slp_mode_ff <= `SCS_SLP_ACTIVE;
    end else begin
      state_ff <= nxt_state;
      to_cnt_ff <= nxt_to_cnt;
      wk_cnt_ff <= nxt_wk_cnt;
      // Last sleep mode requested, decides the wake path
      if (sleep_mode_i != `SCS_SLP_ACTIVE) begin
        slp_mode_ff <= sleep_mode_i;
      end
    end
  end

  // Registers, trim load and lock counter
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pll_enable_bit_ff <= 1'b0;
      t2_sel_ff <= 2'b00;
      rc_trim_value_o <= 8'h00;
      cal_ld_ff <= 1'b1;
      lk_cnt_ff <= 16'd0;
      pll_lock_flag_o <= 1'b0;
    end else begin
      if (cal_ld_ff) begin
        rc_trim_value_o <= factory_cal_i;
        cal_ld_ff <= 1'b0;
      end else if (wr_i && addr_i == `SCS_REG_TRIM) begin
        rc_trim_value_o <= wdata_i;
      end
      if (wr_i && addr_i == `SCS_REG_PLLCS) begin
        pll_enable_bit_ff <= wdata_i[`SCS_PLL_EN_BIT];
      end
      if (wr_i && addr_i == `SCS_REG_T2CLK) begin
        t2_sel_ff <= wdata_i[1:0];
      end
      if (!pll_run || trim_over) begin
        lk_cnt_ff <= 16'd0;
        pll_lock_flag_o <= 1'b0;
      end else if (lk_cnt_ff >= LOCK_CYC) begin
        pll_lock_flag_o <= 1'b1;
      end else begin
        lk_cnt_ff <= lk_cnt_ff + 16'd1;
      end
    end
  end

  // Read port, gated outputs
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
      sys_src_o <= 3'd2;
      xtal_mode_o <= 4'h0;
      rc_osc_en_o <= 1'b0;
      pll_en_o <= 1'b0;
      pll_freq_mhz_o <= 7'd0;
      t2_clk_sel_o <= 2'b00;
      core_clock_en_o <= 1'b0;
      program_memory_clock_en_o <= 1'b0;
      peripheral_io_clock_en_o <= 1'b0;
      converter_clock_en_o <= 1'b0;
      async_irq_en_o <= 1'b0;
      cpu_run_o <= 1'b0;
    end else begin
      rdata_o <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          `SCS_REG_PLLCS: rdata_o <= {6'd0, pll_enable_bit_ff,
                                      pll_lock_flag_o};
          `SCS_REG_TRIM: rdata_o <= rc_trim_value_o;
          `SCS_REG_STAT: rdata_o <= {5'd0, state_ff == ST_WAKE,
                                     state_ff == ST_RSTDLY,
                                     state_ff == ST_RUN};
          `SCS_REG_SLEEP: rdata_o <= {5'd0, sleep_mode_i};
          `SCS_REG_T2CLK: rdata_o <= {6'd0, t2_sel_ff};
          default: rdata_o <= 8'h00;
        endcase
      end
      xtal_mode_o <= clock_source_select_fuses_i;
      case (clock_source_select_fuses_i)
        `SCS_SRC_EXT: sys_src_o <= 3'd0;
        `SCS_SRC_PLL: sys_src_o <= 3'd1;
        `SCS_SRC_RC: sys_src_o <= 3'd2;
        `SCS_SRC_WDOSC: sys_src_o <= 3'd3;
        `SCS_SRC_LFXT: sys_src_o <= 3'd4;
        default: sys_src_o <= clock_source_select_fuses_i[3] ?
                              3'd5 : 3'd7;
      endcase
      rc_osc_en_o <= ~deep_sleep;
      pll_en_o <= pll_run;
      if (!pll_run) begin
        pll_freq_mhz_o <= 7'd0;
      end else if (trim_over) begin
        pll_freq_mhz_o <= 7'd85;
      end else begin
        pll_freq_mhz_o <= pll_mhz[6:0]; // 64 MHz at nominal
      end
      t2_clk_sel_o <= (t2_sel_ff == 2'b11) ? 2'b00 : t2_sel_ff;
      // Sleep gating table
      core_clock_en_o <= (state_ff == ST_RUN);
      program_memory_clock_en_o <= (state_ff == ST_RUN);
      peripheral_io_clock_en_o <= (state_ff == ST_RUN) ||
        (state_ff == ST_SLEEP && sleep_mode_i == `SCS_SLP_IDLE);
      converter_clock_en_o <= (state_ff == ST_RUN) || conv_busy_i ||
        (state_ff == ST_SLEEP && (sleep_mode_i == `SCS_SLP_IDLE ||
         sleep_mode_i == `SCS_SLP_ADCNR));
      async_irq_en_o <= 1'b1;
      cpu_run_o <= (nxt_state == ST_RUN);
    end
  end

endmodule // scs_clock_ctrl

// ==== inc/scs_defs.vh ====
// Constants for the system clock select and PLL control block.
// Assumes inclusion by the design file by bare name; bench files use literal values.
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

// Register map (word-free byte index on plain port)
`define SCS_ADDR_W 4
`define SCS_REG_PLLCS 4'h0
`define SCS_REG_TRIM 4'h1
`define SCS_REG_STAT 4'h2
`define SCS_REG_SLEEP 4'h3
`define SCS_REG_T2CLK 4'h4
// Control/status fields
`define SCS_PLL_EN_BIT 1
`define SCS_LOCK_BIT 0
`define SCS_PLLCS_RST 8'h00
// Status fields
`define SCS_ST_RUN_BIT 0
`define SCS_ST_RSTDLY_BIT 1
`define SCS_ST_WAKE_BIT 2
// Clock source fuse codes
`define SCS_SRC_EXT 4'h0
`define SCS_SRC_PLL 4'h1
`define SCS_SRC_RC 4'h2
`define SCS_SRC_WDOSC 4'h4
`define SCS_SRC_LFXT 4'h6
// Sleep modes
`define SCS_SLP_ACTIVE 3'h0
`define SCS_SLP_IDLE 3'h1
`define SCS_SLP_ADCNR 3'h2
`define SCS_SLP_PDOWN 3'h3
`define SCS_SLP_PSAVE 3'h4
`define SCS_SLP_STBY 3'h5
// PLL
`define SCS_PLL_MULT 8
`define SCS_PLL_IN_KHZ 8000
`define SCS_PLL_OUT_KHZ 64000
`define SCS_PLL_SAT_KHZ 85000
`define SCS_PLL_LOCK_CYC 16'd100
// Reset time-out in ms and watchdog oscillator cycles; wake count in source cycles
`define SCS_TO_SHORT_MS 4
`define SCS_TO_SHORT_CYC 14'd512
`define SCS_TO_LONG_MS 64
`define SCS_TO_LONG_CYC 14'd8192
`define SCS_WAKE_CYC 16'd1024

`endif

// ==== dv/scs_tick_src.sv ====
// Tick source standing in for the watchdog and selected oscillators.
// Assumes one system clock; pulses last one cycle, none during reset.
`timescale 1ns/1ps
module scs_tick_src (
  input wire clk_sys_i, // System clock
  input wire nrst_i, // Reset, active low
  output reg wdosc_tick_o, // Watchdog pulse
  output reg src_tick_o // Source pulse
);
  reg [1:0] cnt_ff;
  // One pulse of each kind every third cycle
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= 2'h0;
      wdosc_tick_o <= 1'b0;
      src_tick_o <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
      wdosc_tick_o <= (cnt_ff == 2'h2);
      src_tick_o <= (cnt_ff == 2'h1);
    end
  end
endmodule // scs_tick_src

// ==== dv/scs_clock_ctrl_props.sv ====
// Checker for the clock select block, watching only its ports.
// Assumes it is bound into every scs_clock_ctrl instance.
`timescale 1ns/1ps
module scs_clock_ctrl_props #(
  parameter [13:0] TO_SHORT_CYC = 14'd512,
  parameter [13:0] TO_LONG_CYC = 14'd8192
) (
  input wire clk_sys_i, // Clock
  input wire nrst_i, // Reset
  input wire pll_system_clock_fuse_i, // PLL fuse
  input wire [1:0] startup_fuses_i, // Delay fuses
  input wire wdosc_tick_i, // Watchdog pulse
  input wire [2:0] sleep_mode_i, // Sleep mode
  input wire conv_busy_i, // Converting
  input wire [7:0] rc_trim_value_o, // Trim
  input wire rc_osc_en_o, // RC on
  input wire pll_en_o, // PLL on
  input wire [6:0] pll_freq_mhz_o, // Rate
  input wire pll_lock_flag_o, // Lock
  input wire core_clock_en_o, // Core
  input wire program_memory_clock_en_o, // Memory
  input wire peripheral_io_clock_en_o, // I/O
  input wire converter_clock_en_o, // Converter
  input wire async_irq_en_o, // Async detect
  input wire cpu_run_o // Run
);
  reg [13:0] tk_ff;
  wire deep = (sleep_mode_i == 3'h3) || (sleep_mode_i == 3'h5);
  wire [13:0] tgt = (startup_fuses_i == 2'b00) ? 14'h0 :
    (startup_fuses_i == 2'b01) ? TO_SHORT_CYC : TO_LONG_CYC;
  // Watchdog ticks seen since reset, saturating
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      tk_ff <= 14'h0;
    else if (wdosc_tick_i && tk_ff != 14'h3fff)
      tk_ff <= tk_ff + 14'h1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  AST_MEM_CORE: assert property (
    program_memory_clock_en_o == core_clock_en_o) else $error("mem clk");
  AST_DEEP_OFF: assert property (
    $past(deep) && $past(deep, 2) |-> !rc_osc_en_o && !pll_en_o)
    else $error("deep sleep");
  AST_FUSE_PLL: assert property (
    $past(nrst_i && !pll_system_clock_fuse_i && !deep) |-> pll_en_o)
    else $error("pll fuse");
  AST_LOCK_OFF: assert property (
    !pll_en_o ##1 !pll_en_o |-> !pll_lock_flag_o) else $error("lock off");
  AST_SATURATE: assert property (
    (pll_en_o && rc_trim_value_o > 8'h80) [*3] |->
    pll_freq_mhz_o == 7'd85 && !pll_lock_flag_o) else $error("saturate");
  AST_NOMINAL: assert property (
    pll_lock_flag_o && rc_trim_value_o == 8'h80 && $stable(rc_trim_value_o)
    |-> pll_freq_mhz_o == 7'd64) else $error("nominal rate");
  AST_RST_DELAY: assert property (
    tk_ff < tgt |-> !cpu_run_o) else $error("reset delay");
  AST_ASYNC: assert property (
    $past(nrst_i) |-> async_irq_en_o) else $error("async detect");
  AST_CONV: assert property (
    $past(nrst_i && sleep_mode_i == 3'h2 && conv_busy_i) &&
    $past(nrst_i && sleep_mode_i == 3'h2 && conv_busy_i, 2) |->
    converter_clock_en_o && !core_clock_en_o && !peripheral_io_clock_en_o)
    else $error("converter domain");
endmodule // scs_clock_ctrl_props
bind scs_clock_ctrl scs_clock_ctrl_props #(
  .TO_SHORT_CYC(TO_SHORT_CYC), .TO_LONG_CYC(TO_LONG_CYC)) u_props (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .pll_system_clock_fuse_i(pll_system_clock_fuse_i),
  .startup_fuses_i(startup_fuses_i), .wdosc_tick_i(wdosc_tick_i),
  .sleep_mode_i(sleep_mode_i), .conv_busy_i(conv_busy_i),
  .rc_trim_value_o(rc_trim_value_o), .rc_osc_en_o(rc_osc_en_o),
  .pll_en_o(pll_en_o), .pll_freq_mhz_o(pll_freq_mhz_o),
  .pll_lock_flag_o(pll_lock_flag_o), .core_clock_en_o(core_clock_en_o),
  .program_memory_clock_en_o(program_memory_clock_en_o),
  .peripheral_io_clock_en_o(peripheral_io_clock_en_o),
  .converter_clock_en_o(converter_clock_en_o),
  .async_irq_en_o(async_irq_en_o), .cpu_run_o(cpu_run_o));

// ==== dv/tb.sv ====
// Self-checking bench for the clock select block.
// Assumes the tick source model drives both oscillator pulses.
`timescale 1ns/1ps
module tb;
  localparam [13:0] TS = 14'd8;
  localparam [13:0] TL = 14'd16;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [3:0] fuse = 4'h2;
  reg pllf = 1'b1;
  reg [1:0] sf = 2'b01;
  reg [2:0] slp = 3'h0;
  reg busy = 1'b0;
  reg [3:0] a = 4'h0;
  reg [7:0] wd = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  wire wt, st, rce, ple, lck, cce, pme, ioe, cve, aie, run;
  wire [7:0] rdat, trim;
  wire [6:0] frq;
  wire [3:0] xm;
  wire [2:0] src;
  wire [1:0] t2;
  integer num_errors = 0;
  integer total_checks = 0;
  integer cyc = 0;
  integer i, n;
  always #5 clk = ~clk;
  scs_tick_src u_tick (.clk_sys_i(clk), .nrst_i(nrst), .wdosc_tick_o(wt),
    .src_tick_o(st));
  scs_clock_ctrl #(.TO_SHORT_CYC(TS), .TO_LONG_CYC(TL), .WAKE_CYC(16'd4),
    .LOCK_CYC(16'd4)) uut (.clk_sys_i(clk), .nrst_i(nrst),
    .clock_source_select_fuses_i(fuse), .pll_system_clock_fuse_i(pllf),
    .startup_fuses_i(sf), .factory_cal_i(8'h5a), .wdosc_tick_i(wt),
    .src_tick_i(st), .sleep_mode_i(slp), .conv_busy_i(busy), .addr_i(a),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .sys_src_o(src),
    .xtal_mode_o(xm), .rc_trim_value_o(trim), .rc_osc_en_o(rce),
    .pll_en_o(ple), .pll_freq_mhz_o(frq), .pll_lock_flag_o(lck),
    .t2_clk_sel_o(t2), .core_clock_en_o(cce),
    .program_memory_clock_en_o(pme), .peripheral_io_clock_en_o(ioe),
    .converter_clock_en_o(cve), .async_irq_en_o(aie), .cpu_run_o(run));
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wrr(input [3:0] ad, input [7:0] d);
    begin
      @(posedge clk) a <= ad;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk) wr <= 1'b0;
      #1;
    end
  endtask
  task rdr(input [3:0] ad, input [7:0] exp);
    begin
      @(posedge clk) a <= ad;
      rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      #1;
      chk(rdat, exp);
    end
  endtask
  task wait_cyc(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  task wait_run;
    begin
      n = 0;
      while (run !== 1'b1 && n < 80) begin
        wait_cyc(1);
        n = n + 1;
      end
    end
  endtask
  function [7:0] exp_src(input [3:0] c);
    begin
      case (c)
        4'h0, 4'h1, 4'h2: exp_src = {4'h0, c};
        4'h4: exp_src = 8'h3;
        4'h6: exp_src = 8'h4;
        4'h3, 4'h5, 4'h7: exp_src = 8'h7;
        default: exp_src = 8'h5;
      endcase
    end
  endfunction
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end
  initial begin
    for (i = 1; i < 3; i = i + 1) begin
      @(posedge clk) nrst <= 1'b0;
      sf <= i[1:0];
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      #1;
      n = 0;
      while (run !== 1'b1) begin
        if (wt === 1'b1) n = n + 1;
        wait_cyc(1);
      end
      chk(n[7:0], (i == 1) ? TS[7:0] : TL[7:0]);
      chk(trim, 8'h5a);
    end
    $display("test reset delay done");
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge clk) fuse <= i[3:0];
      wait_cyc(2);
      chk(src, exp_src(i));
      chk(xm, i[7:0]);
    end
    @(posedge clk) fuse <= 4'h2;
    $display("test source select done");
    wrr(4'h1, 8'h80);
    rdr(4'h0, 8'h00);
    wrr(4'h0, 8'h02);
    wait_cyc(12);
    rdr(4'h0, 8'h03);
    chk(frq, 8'd64);
    wrr(4'h1, 8'h90);
    wait_cyc(4);
    chk({lck, frq}, 8'd85);
    wrr(4'h1, 8'h80);
    wrr(4'h0, 8'h00);
    wait_cyc(2);
    chk({ple, lck}, 8'h00);
    @(posedge clk) pllf <= 1'b0;
    wait_cyc(2);
    chk(ple, 8'h01);
    @(posedge clk) pllf <= 1'b1;
    $display("test pll done");
    for (i = 1; i < 6; i = i + 1) begin
      @(posedge clk) slp <= i[2:0];
      busy <= (i == 2);
      wait_cyc(3);
      chk(cce, 8'h00);
      chk(pme, 8'h00);
      chk(aie, 8'h01);
      chk(cve, (i < 3) ? 8'h01 : 8'h00);
      if (i == 4) chk(rce, 8'h01);
      if (i == 1) chk(ioe, 8'h01);
      if (i == 3 || i == 5) chk({rce, ple}, 8'h00);
      rdr(4'h3, i[7:0]);
      @(posedge clk) slp <= 3'h0;
      busy <= 1'b0;
      wait_cyc(2);
      if (i >= 3) chk(run, 8'h00);
      wait_run;
      chk(run, 8'h01);
    end
    $display("test sleep done");
    for (i = 0; i < 4; i = i + 1) begin
      wrr(4'h4, i[7:0]);
      wait_cyc(1);
      chk(t2, (i == 3) ? 8'h00 : i[7:0]);
    end
    wrr(4'hf, 8'hff);
    rdr(4'hf, 8'h00);
    $display("test timer clock done");
    complete_run;
  end
endmodule // tb
